/* verilog/pep_pkg.sv */
// Shared constants for the port E / host parallel port pair.
// Assumes a single 100 MHz clock on both ends.
package pep_pkg;
   localparam int DW = 8;
   localparam int EW = 3;
   localparam int AW = 4;
   // CPU-side register offsets.
   localparam logic [3:0] ADDR_E_DIR = 4'h0;
   localparam logic [3:0] ADDR_E_LAT = 4'h1;
   localparam logic [3:0] ADDR_D_LAT = 4'h2;
   localparam logic [3:0] ADDR_E_PIN = 4'h3;
   localparam logic [3:0] ADDR_D_PIN = 4'h4;
   localparam logic [3:0] ADDR_D_DIR = 4'h5;
   localparam logic [3:0] ADDR_IRQ_PRI = 4'h6;
   localparam logic [3:0] ADDR_IRQ_FLG = 4'h7;
   localparam logic [3:0] ADDR_IRQ_ENA = 4'h8;
   localparam logic [3:0] ADDR_ANA_CTL = 4'h9;
   localparam logic [3:0] ADDR_IRQ_CTL = 4'ha;
   // Direction / status and interrupt control register fields.
   localparam int BIT_IBF = 7;
   localparam int BIT_OBF = 6;
   localparam int BIT_INPUT_OVERFLOW = 5;
   localparam int BIT_MODE = 4;
   localparam int BIT_HOST_IRQ = 7;
   localparam int BIT_PRI_EN = 7;
   localparam int BIT_PER_GATE = 6;
   // Port E pin roles in host-port mode.
   localparam int PIN_RD = 0;
   localparam int PIN_WR = 1;
   localparam int PIN_CS = 2;
   // Reset values.
   localparam logic [2:0] RST_E_DIR = 3'h7;
   localparam logic [7:0] RST_D_DIR = 8'hff;
   localparam logic [7:0] RST_IRQ_PRI = 8'hff;
   localparam logic [7:0] RST_ZERO8 = 8'h00;
   localparam logic [2:0] RST_ZERO3 = 3'h0;
   localparam logic [2:0] RST_ANA_CFG = 3'h0;
   // Host strobe timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_TIME_NS = 80;
   localparam int GAP_TIME_NS = 40;
   localparam int STROBE_CYC = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
   localparam logic [3:0] GAP_LAST = 4'(GAP_CYC - 1);
endpackage

/* verilog/pep_bus_if.sv */
// Pins between the device port and the external microprocessor.
// Resolves each shared wire from the output enables; undriven data floats high.
`timescale 1ns/10ps
`default_nettype none
interface pep_bus_if;
   logic [2:0] dev_e_out;
   logic [2:0] dev_e_oe_n;
   logic [7:0] dev_d_out;
   logic [7:0] dev_d_oe_n;
   logic host_rd_n;
   logic host_wr_n;
   logic host_cs_n;
   logic [7:0] host_d_out;
   logic host_d_oe_n;
   logic [2:0] e_line;
   logic [7:0] d_line;
   logic [2:0] host_e;
   assign host_e = {host_cs_n, host_wr_n, host_rd_n};
   genvar i;
   for (i = 0; i < 3; i++)
   begin : g_e
      assign e_line[i] = ~dev_e_oe_n[i] ? dev_e_out[i] : host_e[i];
   end
   for (i = 0; i < 8; i++)
   begin : g_d
      assign d_line[i] = ~dev_d_oe_n[i] ? dev_d_out[i] : (~host_d_oe_n ? host_d_out[i] : 1'b1);
   end
   modport dev (input e_line, input d_line, output dev_e_out, output dev_e_oe_n,
                output dev_d_out, output dev_d_oe_n);
   modport host (input d_line, output host_rd_n, output host_wr_n, output host_cs_n,
                 output host_d_out, output host_d_oe_n);
endinterface
`default_nettype wire

/* verilog/pep_device.sv */
// Port E with its host parallel slave port, CPU register file and host-port interrupt.
// Assumes pins arrive asynchronously and the CPU port is on i_mclk.
// Function
// - Three port E pins, each configurable
// - Direction one tri-states, zero drives latch
// - Latch register reads back latch, not pins
// - Analog-selected pins read as zero
// - Direction still drives pins in analog
// - Reset: pins inputs, analog configuration
// - Mode bit turns port D into slave
// - Mode maps pins to read, write, select
// - Software sets pins input and digital first
// - Select and write low latches host byte
// - Select and read low starts host read
// - Host treats port D as one latch
// - Enable bit seven gates host interrupt
// - Without priority, peripheral gate also needed
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pep_device
   import pep_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [pep_pkg::AW-1:0] i_addr,
   input wire logic [pep_pkg::DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [pep_pkg::DW-1:0] o_rdata,
   output logic o_irq,
   pep_bus_if.dev bus
);
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   // Pins read digital only when both upper configuration bits are set.
   function automatic logic [2:0] analog_mask(input logic [2:0] cfg);
      analog_mask = (cfg[2] & cfg[1]) ? 3'h0 : 3'h7;
   endfunction

   logic [2:0] e_s1_ff, e_s2_ff;
   logic [7:0] d_s1_ff, d_s2_ff;
   logic [2:0] e_dir_ff, e_lat_ff, ana_cfg_ff;
   logic mode_ff, ibf_ff, obf_ff, input_overflow_ff;
   logic [7:0] d_lat_ff, d_dir_ff, in_buf_ff;
   logic [7:0] irq_pri_ff, irq_flg_ff, irq_ena_ff;
   logic pri_en_ff, per_gate_ff;
   logic wr_act_ff, rd_act_ff;
   logic [7:0] rdata_ff, d_oe_n_ff;
   logic irq_ff;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         e_s1_ff <= 3'h7;
         e_s2_ff <= 3'h7;
         d_s1_ff <= RST_ZERO8;
         d_s2_ff <= RST_ZERO8;
      end
      else if (i_ce)
      begin
         e_s1_ff <= bus.e_line;
         e_s2_ff <= e_s1_ff;
         d_s1_ff <= bus.d_line;
         d_s2_ff <= d_s1_ff;
      end
   end

   wire cs_low = ~e_s2_ff[PIN_CS];
   wire wr_act = mode_ff & cs_low & ~e_s2_ff[PIN_WR];
   wire rd_act = mode_ff & cs_low & ~e_s2_ff[PIN_RD];
   wire wr_start = wr_act & ~wr_act_ff;
   wire rd_start = rd_act & ~rd_act_ff;

   wire w_e_dir = i_wr & hit(i_addr, ADDR_E_DIR);
   wire w_e_lat = i_wr & (hit(i_addr, ADDR_E_LAT) | hit(i_addr, ADDR_E_PIN));
   wire w_d_lat = i_wr & (hit(i_addr, ADDR_D_LAT) | hit(i_addr, ADDR_D_PIN));
   wire w_d_dir = i_wr & hit(i_addr, ADDR_D_DIR);
   wire w_pri = i_wr & hit(i_addr, ADDR_IRQ_PRI);
   wire w_flg = i_wr & hit(i_addr, ADDR_IRQ_FLG);
   wire w_ena = i_wr & hit(i_addr, ADDR_IRQ_ENA);
   wire w_ana = i_wr & hit(i_addr, ADDR_ANA_CTL);
   wire w_ctl = i_wr & hit(i_addr, ADDR_IRQ_CTL);
   wire r_d_pin = i_rd & hit(i_addr, ADDR_D_PIN);

   // status flag updates, hardware set wins
   wire nxt_ibf = wr_start | (ibf_ff & ~(r_d_pin & mode_ff));
   wire nxt_input_overflow = (wr_start & ibf_ff) | (input_overflow_ff & ~(w_e_dir & ~i_wdata[BIT_INPUT_OVERFLOW]));
   wire nxt_obf = (w_d_lat & mode_ff) | (obf_ff & ~rd_start);
   wire host_evt = wr_start | rd_start;
   wire [7:0] flg_base = w_flg ? i_wdata : irq_flg_ff;
   wire [7:0] nxt_irq_flg = flg_base | {host_evt, 7'h0};

   wire [2:0] e_pin_val = e_s2_ff & ~analog_mask(ana_cfg_ff);
   // port D read returns host byte in slave mode
   wire [7:0] d_pin_val = mode_ff ? in_buf_ff : d_s2_ff;
   wire route_ok = pri_en_ff | per_gate_ff;
   wire nxt_irq = irq_flg_ff[BIT_HOST_IRQ] & irq_ena_ff[BIT_HOST_IRQ] & route_ok;

   logic [7:0] rd_mux;
   always_comb
   begin
      case (i_addr)
         ADDR_E_DIR: rd_mux = {ibf_ff, obf_ff, input_overflow_ff, mode_ff, 1'b0, e_dir_ff};
         ADDR_E_LAT: rd_mux = {5'h0, e_lat_ff};
         ADDR_D_LAT: rd_mux = d_lat_ff;
         ADDR_E_PIN: rd_mux = {5'h0, e_pin_val};
         ADDR_D_PIN: rd_mux = d_pin_val;
         ADDR_D_DIR: rd_mux = d_dir_ff;
         ADDR_IRQ_PRI: rd_mux = irq_pri_ff;
         ADDR_IRQ_FLG: rd_mux = irq_flg_ff;
         ADDR_IRQ_ENA: rd_mux = irq_ena_ff;
         ADDR_ANA_CTL: rd_mux = {5'h0, ana_cfg_ff};
         ADDR_IRQ_CTL: rd_mux = {pri_en_ff, per_gate_ff, 6'h0};
         default: rd_mux = RST_ZERO8;
      endcase
   end

   // Drive the whole byte while a host read is seen, so the host samples a stable latch.
   wire [7:0] nxt_d_oe_n = mode_ff ? {8{~rd_act}} : d_dir_ff;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         e_dir_ff <= RST_E_DIR;
         ana_cfg_ff <= RST_ANA_CFG;
         mode_ff <= 1'b0;
         e_lat_ff <= RST_ZERO3;
         d_lat_ff <= RST_ZERO8;
         d_dir_ff <= RST_D_DIR;
         irq_pri_ff <= RST_IRQ_PRI;
         pri_en_ff <= 1'b0;
         per_gate_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         if (w_e_dir)
         begin
            e_dir_ff <= i_wdata[2:0];
            mode_ff <= i_wdata[BIT_MODE];
         end
         if (w_e_lat)
            e_lat_ff <= i_wdata[2:0];
         if (w_d_lat)
            d_lat_ff <= i_wdata;
         if (w_d_dir)
            d_dir_ff <= i_wdata;
         if (w_pri)
            irq_pri_ff <= i_wdata;
         if (w_ana)
            ana_cfg_ff <= i_wdata[2:0];
         if (w_ctl)
         begin
            pri_en_ff <= i_wdata[BIT_PRI_EN];
            per_gate_ff <= i_wdata[BIT_PER_GATE];
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         ibf_ff <= 1'b0;
         obf_ff <= 1'b0;
         input_overflow_ff <= 1'b0;
         in_buf_ff <= RST_ZERO8;
         irq_flg_ff <= RST_ZERO8;
         irq_ena_ff <= RST_ZERO8;
         wr_act_ff <= 1'b0;
         rd_act_ff <= 1'b0;
         rdata_ff <= RST_ZERO8;
         d_oe_n_ff <= RST_D_DIR;
         irq_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         ibf_ff <= nxt_ibf;
         obf_ff <= nxt_obf;
         input_overflow_ff <= nxt_input_overflow;
         if (wr_start)
            in_buf_ff <= d_s2_ff;
         irq_flg_ff <= nxt_irq_flg;
         if (w_ena)
            irq_ena_ff <= i_wdata;
         wr_act_ff <= wr_act;
         rd_act_ff <= rd_act;
         rdata_ff <= i_rd ? rd_mux : RST_ZERO8;
         d_oe_n_ff <= nxt_d_oe_n;
         irq_ff <= nxt_irq;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_irq = irq_ff;
   assign bus.dev_e_out = e_lat_ff;
   assign bus.dev_e_oe_n = e_dir_ff;
   assign bus.dev_d_out = d_lat_ff;
   assign bus.dev_d_oe_n = d_oe_n_ff;
endmodule
`default_nettype wire

/* verilog/pep_host.sv */
// External microprocessor end: turns user write and read requests into strobe cycles.
// Assumes the device runs host-port mode with its pins set as digital inputs.
`timescale 1ns/10ps
`default_nettype none
module pep_host
   import pep_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_wr_req,
   input wire logic i_rd_req,
   input wire logic [pep_pkg::DW-1:0] i_wdata,
   output logic [pep_pkg::DW-1:0] o_rdata,
   output logic o_rvalid,
   output logic o_busy,
   pep_bus_if.host bus
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WRITE = 4'h2,
      ST_READ = 4'h4,
      ST_GAP = 4'h8
   } pep_state_e;

   pep_state_e state_ff, nxt_state;
   logic [3:0] cnt_ff;
   logic [7:0] d_s1_ff, d_s2_ff, rdata_ff, wdata_ff;
   logic rvalid_ff, cs_n_ff, wr_n_ff, rd_n_ff, d_oe_n_ff, busy_ff;

   wire strobe_done = (cnt_ff == STROBE_LAST);
   wire gap_done = (cnt_ff == GAP_LAST);

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (i_wr_req)
               nxt_state = ST_WRITE;
            else if (i_rd_req)
               nxt_state = ST_READ;
         ST_WRITE:
            if (strobe_done)
               nxt_state = ST_GAP;
         ST_READ:
            if (strobe_done)
               nxt_state = ST_GAP;
         ST_GAP:
            if (gap_done)
               nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   wire leaving = (nxt_state != state_ff);
   wire nxt_wr_active = (nxt_state == ST_WRITE);
   wire nxt_rd_active = (nxt_state == ST_READ);
   wire capture = (state_ff == ST_READ) & strobe_done;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         d_s1_ff <= RST_ZERO8;
         d_s2_ff <= RST_ZERO8;
         rdata_ff <= RST_ZERO8;
         wdata_ff <= RST_ZERO8;
         rvalid_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         d_oe_n_ff <= 1'b1;
         busy_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         state_ff <= nxt_state;
         cnt_ff <= leaving ? 4'h0 : cnt_ff + 4'h1;
         d_s1_ff <= bus.d_line;
         d_s2_ff <= d_s1_ff;
         if (state_ff == ST_IDLE && i_wr_req)
            wdata_ff <= i_wdata;
         if (capture)
            rdata_ff <= d_s2_ff;
         rvalid_ff <= capture;
         cs_n_ff <= ~(nxt_wr_active | nxt_rd_active);
         wr_n_ff <= ~nxt_wr_active;
         rd_n_ff <= ~nxt_rd_active;
         d_oe_n_ff <= ~nxt_wr_active;
         // Registered so the busy output follows the state register exactly.
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   assign o_rdata = rdata_ff;
   assign o_rvalid = rvalid_ff;
   assign o_busy = busy_ff;
   assign bus.host_cs_n = cs_n_ff;
   assign bus.host_wr_n = wr_n_ff;
   assign bus.host_rd_n = rd_n_ff;
   assign bus.host_d_out = wdata_ff;
   assign bus.host_d_oe_n = d_oe_n_ff;
endmodule
`default_nettype wire

/* test/pep_monitor.sv */
// Concurrent checks on the host link between the device end and the microprocessor end.
// Assumes port D direction stays at its reset value and host reads happen in host mode.
`timescale 1ns/10ps
`default_nettype none
module pep_monitor (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [7:0] dev_d_oe_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic host_cs_n,
   input wire logic [7:0] host_d_out,
   input wire logic host_d_oe_n
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   a_strobe_len: assert property ($fell(host_cs_n) |-> (!host_cs_n) [*8] ##1 host_cs_n)
      else $error("select low time wrong");
   a_gap_len: assert property ($rose(host_cs_n) |-> host_cs_n [*4])
      else $error("gap between accesses too short");
   a_select_frames: assert property (host_cs_n |-> (host_rd_n && host_wr_n))
      else $error("strobe low outside select");
   a_one_strobe: assert property (!(!host_rd_n && !host_wr_n))
      else $error("read and write strobes low together");
   a_wr_drives: assert property (!host_wr_n |-> !host_d_oe_n)
      else $error("write strobe without host data drive");
   a_wdata_stable: assert property ((!host_wr_n && $past(host_wr_n) == 1'b0) |-> $stable(host_d_out))
      else $error("host write data moved during strobe");
   a_read_drive: assert property ($fell(host_rd_n) |-> ##[1:5] (dev_d_oe_n == 8'h00))
      else $error("device did not drive port D for host read");
   a_read_release: assert property ($rose(host_rd_n) |-> ##[1:5] (dev_d_oe_n == 8'hff))
      else $error("device kept driving port D after read");
   a_no_clash: assert property (!(!host_d_oe_n && dev_d_oe_n != 8'hff))
      else $error("both ends drive port D");
endmodule
`default_nettype wire

/* test/pep_bench.sv */
// Self-checking bench: device and microprocessor ends joined by the bus interface.
// Assumes one 100 MHz clock and a synchronous active-low reset for both ends.
`timescale 1ns/10ps
`default_nettype none
module pep_bench;
   import pep_pkg::*;
   logic i_mclk, i_rst_n, i_wr, i_rd, h_wr, h_rd, ce;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, h_wdata, o_rdata, h_rdata;
   logic o_irq, h_rvalid, h_busy;
   int error_cnt = 0;
   int n_checks = 0;
   pep_bus_if bus_w();
   pep_device i_pep_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .bus(bus_w));
   pep_host i_pep_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_wr_req(h_wr),
      .i_rd_req(h_rd), .i_wdata(h_wdata), .o_rdata(h_rdata), .o_rvalid(h_rvalid),
      .o_busy(h_busy), .bus(bus_w));
   pep_monitor i_pep_monitor (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .dev_d_oe_n(bus_w.dev_d_oe_n),
      .host_rd_n(bus_w.host_rd_n), .host_wr_n(bus_w.host_wr_n), .host_cs_n(bus_w.host_cs_n),
      .host_d_out(bus_w.host_d_out), .host_d_oe_n(bus_w.host_d_oe_n));
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic cpu_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so it is sampled there.
   task automatic cpu_rd(input logic [3:0] a, input string nm, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(nm, exp, o_rdata);
   endtask
   task automatic host_op(input logic wr, input logic [7:0] d);
      logic seen;
      seen = 1'b0;
      @(posedge i_mclk);
      h_wr <= wr;
      h_rd <= !wr;
      h_wdata <= d;
      @(posedge i_mclk);
      h_wr <= 1'b0;
      h_rd <= 1'b0;
      // Busy is launched by this very edge, so look only once it has settled.
      #1;
      for (int n = 0; n < 40 && h_busy !== 1'b0; n++)
      begin
         @(posedge i_mclk);
         #1 seen = seen | (h_rvalid === 1'b1);
      end
      if (h_busy !== 1'b0)
      begin
         $display("MISMATCH host busy expected 0 seen %b", h_busy);
         error_cnt++;
         complete_run();
      end
      if (!wr)
         chk("host rvalid", 8'h01, {7'h0, seen});
   endtask
   task automatic t_reset;
      cpu_rd(ADDR_E_DIR, "e dir", 8'h07);
      cpu_rd(ADDR_D_DIR, "d dir", 8'hff);
      cpu_rd(ADDR_IRQ_PRI, "irq pri", 8'hff);
      cpu_rd(ADDR_IRQ_FLG, "irq flg", 8'h00);
      cpu_rd(ADDR_IRQ_ENA, "irq ena", 8'h00);
      cpu_rd(ADDR_E_PIN, "e pins analog", 8'h00);
      cpu_rd(4'hb, "unmapped", 8'h00);
      $display("reset test done");
   endtask
   task automatic t_port_e;
      cpu_wr(ADDR_ANA_CTL, 8'h06);
      cpu_wr(ADDR_E_LAT, 8'h05);
      cpu_wr(ADDR_E_DIR, 8'h00);
      repeat (3) @(posedge i_mclk);
      cpu_rd(ADDR_E_PIN, "e pins driven", 8'h05);
      cpu_wr(ADDR_ANA_CTL, 8'h00);
      repeat (3) @(posedge i_mclk);
      cpu_rd(ADDR_E_PIN, "e pins analog", 8'h00);
      chk("e drive in analog", 8'h00, {5'h0, bus_w.dev_e_oe_n});
      cpu_wr(ADDR_ANA_CTL, 8'h06);
      cpu_wr(ADDR_E_DIR, 8'h07);
      repeat (3) @(posedge i_mclk);
      cpu_rd(ADDR_E_PIN, "e pins input", 8'h07);
      cpu_rd(ADDR_E_LAT, "e latch", 8'h05);
      cpu_wr(ADDR_E_PIN, 8'h02);
      cpu_rd(ADDR_E_LAT, "e pin write", 8'h02);
      $display("port E test done");
   endtask
   // A write offered while the clock enable is low must leave the latch alone.
   task automatic t_freeze;
      @(posedge i_mclk);
      ce <= 1'b0;
      cpu_wr(ADDR_E_LAT, 8'h05);
      @(posedge i_mclk);
      ce <= 1'b1;
      cpu_rd(ADDR_E_LAT, "e latch frozen", 8'h02);
      $display("freeze test done");
   endtask
   task automatic t_host_write;
      host_op(1'b1, 8'h3c);
      cpu_rd(ADDR_E_DIR, "ibf mode off", 8'h07);
      cpu_wr(ADDR_E_DIR, 8'h17);
      cpu_wr(ADDR_IRQ_ENA, 8'h80);
      cpu_wr(ADDR_IRQ_CTL, 8'h40);
      host_op(1'b1, 8'ha5);
      cpu_rd(ADDR_E_DIR, "ibf set", 8'h97);
      cpu_rd(ADDR_IRQ_FLG, "flag set", 8'h80);
      chk("irq gated on", 8'h01, {7'h0, o_irq});
      cpu_rd(ADDR_D_PIN, "host byte", 8'ha5);
      host_op(1'b1, 8'h5a);
      host_op(1'b1, 8'hc3);
      cpu_rd(ADDR_E_DIR, "overflow", 8'hb7);
      cpu_rd(ADDR_D_PIN, "last byte", 8'hc3);
      cpu_wr(ADDR_E_DIR, 8'h17);
      cpu_rd(ADDR_E_DIR, "overflow cleared", 8'h17);
      cpu_wr(ADDR_IRQ_CTL, 8'h00);
      repeat (2) @(posedge i_mclk);
      chk("irq no gate", 8'h00, {7'h0, o_irq});
      cpu_wr(ADDR_IRQ_CTL, 8'h80);
      repeat (2) @(posedge i_mclk);
      chk("irq priority", 8'h01, {7'h0, o_irq});
      cpu_wr(ADDR_IRQ_ENA, 8'h00);
      repeat (2) @(posedge i_mclk);
      chk("irq disabled", 8'h00, {7'h0, o_irq});
      cpu_wr(ADDR_IRQ_FLG, 8'h00);
      $display("host write test done");
   endtask
   task automatic t_host_read;
      cpu_wr(ADDR_D_LAT, 8'h69);
      cpu_rd(ADDR_E_DIR, "obf set", 8'h57);
      host_op(1'b0, 8'h00);
      chk("host read byte", 8'h69, h_rdata);
      cpu_rd(ADDR_E_DIR, "obf cleared", 8'h17);
      cpu_rd(ADDR_IRQ_FLG, "read flag", 8'h80);
      $display("host read test done");
   endtask
   initial
   begin
      i_rst_n = 1'b0;
      ce = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      h_wr = 1'b0;
      h_rd = 1'b0;
      h_wdata = 8'h00;
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_reset();
      t_port_e();
      t_freeze();
      t_host_write();
      t_host_read();
      complete_run();
   end
endmodule
`default_nettype wire
